// >>> rtl/ltirq_top.v
// threshold comparison, flags, interrupt pin and register slave
`timescale 1ns/10ps
`include "ltirq_defs.vh"

// register map; every word reads back 32 bits, upper bits zero
//   0x0 configuration: above and below flags are read only,
//       then latch select, polarity, exponent mask, fault select
//   0x4 result view, read only, exponent hidden on request in manual range only
//   0x8 event status, sticky; a read clears the bits it returned
//   0xc event mask, same layout as the status word
// unmapped words read zero and drop writes; a write only lands
// when byte lane zero is enabled, the other lanes are ignored
// measurement timing: the filters count at the strobe edge,
// flags, status, pin and irq all move one edge later

module ltirq_top #(
  parameter CW = 4
) (
  ref_clk,          // 20 MHz clock
  rst_n,            // async reset, active low
  avs_address,      // byte address
  avs_read,         // read request
  avs_write,        // write request
  avs_writedata,    // write data
  avs_byteenable,   // byte lanes
  avs_readdata,     // read data
  avs_waitrequest,  // stall
  irq,              // level interrupt to software
  meas_valid,       // new conversion done
  meas_result,      // conversion result word
  low_limit,        // low limit word
  high_limit,       // high limit word
  range_number,     // range setting of the sensor
  int_pin_in,       // interrupt pin level seen
  int_pin_out,      // interrupt pin drive value
  int_pin_oe,       // interrupt pin drive enable
  below_limit_flag, // below flag to the sensor
  above_limit_flag  // above flag to the sensor
);
  input  wire        ref_clk;          // clock
  input  wire        rst_n;            // reset
  input  wire [3:0]  avs_address;      // address
  input  wire        avs_read;         // read
  input  wire        avs_write;        // write
  input  wire [31:0] avs_writedata;    // data in
  input  wire [3:0]  avs_byteenable;   // lanes
  output wire [31:0] avs_readdata;     // data out
  output wire        avs_waitrequest;  // stall
  output wire        irq;              // interrupt
  input  wire        meas_valid;       // strobe
  input  wire [15:0] meas_result;      // result
  input  wire [15:0] low_limit;        // low limit
  input  wire [15:0] high_limit;       // high limit
  input  wire [3:0]  range_number;     // range
  input  wire        int_pin_in;       // unused level
  output wire        int_pin_out;      // drive value
  output wire        int_pin_oe;       // drive enable
  output wire        below_limit_flag; // flag
  output wire        above_limit_flag; // flag

  // configuration state
  reg        latch_q;
  reg        pol_q;
  reg        mask_q;
  reg [1:0]  fsel_q;

  // flags and pin state
  reg        below_q;
  reg        above_q;
  reg        below_d;
  reg        above_d;
  reg        pin_oe_q;
  reg        pin_out_q;

  // interrupt status and mask
  reg [1:0]  sts_q;
  reg [1:0]  sts_d;
  reg [1:0]  msk_q;
  reg        irq_q;

  // bus state
  reg        wait_q;
  reg [31:0] rdata_q;
  reg [31:0] rdata_d;

  // scaled words, fault verdicts and bus decode
  wire [22:0] res_lux;
  wire [22:0] low_lux;
  wire [22:0] high_lux;
  wire        is_below;
  wire        is_above;
  wire        below_hit;
  wire        below_ev;
  wire        above_hit;
  wire        above_ev;
  wire        bus_req;
  wire        bus_take;
  wire        sel_cfg;
  wire        sel_res;
  wire        sel_sts;
  wire        sel_msk;
  wire        wr_cfg;
  wire        wr_msk;
  wire        rd_cfg;
  wire        rd_sts;
  wire        alert;
  wire [15:0] res_view;

  // the three words go to one scale so exponents may differ;
  // the result is scaled unmasked, masking is a read view only,
  // so hiding the exponent never moves a comparison
  ltirq_lux_scale u_res_scale (
    .val (meas_result),
    .lux (res_lux)
  );

  ltirq_lux_scale u_low_scale (
    .val (low_limit),
    .lux (low_lux)
  );

  ltirq_lux_scale u_high_scale (
    .val (high_limit),
    .lux (high_lux)
  );

  // fault conditions on the unmasked result
  assign is_below = (res_lux < low_lux);
  assign is_above = (res_lux > high_lux);

  // separate filters so one limit never resets the other; both
  // share the fault select, so a change of select applies to the
  // counts already gathered at the next measurement
  ltirq_fault_filter #(
    .CW (CW)
  ) u_below_filt (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .meas_valid (meas_valid),
    .cond       (is_below),
    .fault_sel  (fsel_q),
    .hit        (below_hit),
    .hit_ev     (below_ev)
  );

  ltirq_fault_filter #(
    .CW (CW)
  ) u_above_filt (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .meas_valid (meas_valid),
    .cond       (is_above),
    .fault_sel  (fsel_q),
    .hit        (above_hit),
    .hit_ev     (above_ev)
  );

  // exponent hidden only in the software view, manual range only
  assign res_view = (mask_q && (range_number < `LT_RN_AUTO)) ?
                    {`LT_EXP_ZERO, meas_result[`LT_MANT_HI:0]} :
                    meas_result;

  // one wait cycle: data is fetched on the first edge of a request
  // and the access completes on the edge where waitrequest is low;
  // side effects of a read (flag and status clears) and the landing
  // of a write both happen at that completing edge, never earlier,
  // so a request that is still waiting has changed nothing yet
  assign bus_req  = avs_read | avs_write;
  assign bus_take = bus_req & ~wait_q;

  // address decode shared by the strobes and the read mux
  assign sel_cfg  = (avs_address == `LT_ADDR_CFG);
  assign sel_res  = (avs_address == `LT_ADDR_RES);
  assign sel_sts  = (avs_address == `LT_ADDR_STS);
  assign sel_msk  = (avs_address == `LT_ADDR_MSK);

  // write strobes need the low byte lane, other lanes are ignored
  assign wr_cfg   = bus_take & avs_write & avs_byteenable[`LT_WR_LANE] & sel_cfg;
  assign wr_msk   = bus_take & avs_write & avs_byteenable[`LT_WR_LANE] & sel_msk;
  assign rd_cfg   = bus_take & avs_read & sel_cfg;
  assign rd_sts   = bus_take & avs_read & sel_sts;

  // read data mux, unmapped addresses read zero; it feeds a register
  // so readdata comes straight from a flip-flop
  always @* begin
    rdata_d = 32'h0000_0000;
    if (sel_cfg) begin
      rdata_d[`LT_CFG_ABOVE]                  = above_q;
      rdata_d[`LT_CFG_BELOW]                  = below_q;
      rdata_d[`LT_CFG_LATCH]                  = latch_q;
      rdata_d[`LT_CFG_POL]                    = pol_q;
      rdata_d[`LT_CFG_MASK]                   = mask_q;
      rdata_d[`LT_CFG_FSEL_HI:`LT_CFG_FSEL_LO] = fsel_q;
    end else if (sel_res) begin
      rdata_d[`LT_EXP_HI:0] = res_view;
    end else if (sel_sts) begin
      rdata_d[`LT_STS_ABOVE:`LT_STS_BELOW] = sts_q;
    end else if (sel_msk) begin
      rdata_d[`LT_STS_ABOVE:`LT_STS_BELOW] = msk_q;
    end
  end

  // bus handshake and read data register; waitrequest idles high so
  // every request sees exactly one wait cycle, the data is captured
  // while waiting and stands until the next request's first edge
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      if (bus_take)
        wait_q <= 1'b1;
      else if (bus_req)
        wait_q <= 1'b0;
      if (bus_req && wait_q)
        rdata_q <= rdata_d;
    end
  end

  // configuration register; the flag bits are not writable and a
  // write with the low lane disabled leaves every field alone
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_q <= `LT_LATCH_RST;
      pol_q   <= `LT_POL_RST;
      mask_q  <= `LT_MASK_RST;
      fsel_q  <= `LT_FSEL_RST;
    end else if (wr_cfg) begin
      latch_q <= avs_writedata[`LT_CFG_LATCH];
      pol_q   <= avs_writedata[`LT_CFG_POL];
      mask_q  <= avs_writedata[`LT_CFG_MASK];
      fsel_q  <= avs_writedata[`LT_CFG_FSEL_HI:`LT_CFG_FSEL_LO];
    end
  end

  // flag next state
  // transparent style: each flag is the verdict of the newest
  // measurement, so it can drop again without any software action
  // latched style: a verdict sets the flag and only a configuration
  // read clears it; writes do not clear
  // a read clears only flags it returned, so an event that landed
  // during the wait cycle is not lost; a new event wins over clear
  always @* begin
    if (latch_q) begin
      below_d = below_ev |
                (below_q & ~(rd_cfg & rdata_q[`LT_CFG_BELOW]));
      above_d = above_ev |
                (above_q & ~(rd_cfg & rdata_q[`LT_CFG_ABOVE]));
    end else begin
      below_d = below_hit;
      above_d = above_hit;
    end
  end

  // flag registers, both clear in reset so no false alert
  // reaches the pin when reset is released
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      below_q <= 1'b0;
      above_q <= 1'b0;
    end else begin
      below_q <= below_d;
      above_q <= above_d;
    end
  end

  // pin follows the flags of the selected style; using the next
  // flag state keeps the pin in the same cycle as the flags
  assign alert = below_d | above_d;

  // open drain: only ever drives low, released otherwise
  // polarity zero pulls low on an alert; polarity one pulls low
  // while idle and releases on an alert, so it needs the board
  // pull-up to read high; the pin stays released during reset
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_oe_q  <= 1'b0;
      pin_out_q <= 1'b0;
    end else begin
      pin_out_q <= 1'b0;
      if (pol_q)
        pin_oe_q <= ~alert;
      else
        pin_oe_q <= alert;
    end
  end

  // sticky status, cleared by reading it; set wins over clear
  // like the latched flags, a read clears only the bits it returned,
  // so an event that lands while the read waits is kept for later
  always @* begin
    sts_d = sts_q;
    if (rd_sts)
      sts_d = sts_q & ~rdata_q[`LT_STS_ABOVE:`LT_STS_BELOW];
    sts_d[`LT_STS_BELOW] = sts_d[`LT_STS_BELOW] | below_ev;
    sts_d[`LT_STS_ABOVE] = sts_d[`LT_STS_ABOVE] | above_ev;
  end

  // status, mask and interrupt registers
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sts_q <= `LT_STS_RST;
      msk_q <= `LT_MSK_RST;
      irq_q <= 1'b0;
    end else begin
      sts_q <= sts_d;
      if (wr_msk)
        msk_q <= avs_writedata[`LT_STS_ABOVE:`LT_STS_BELOW];
      // next-state terms keep irq in step with status, and a mask
      // write reaches irq at the same edge as it reaches the mask
      irq_q <= |(sts_d & (wr_msk ? avs_writedata[`LT_STS_ABOVE:`LT_STS_BELOW] : msk_q));
    end
  end

  // outputs straight from flip-flops, so none of them glitches or
  // depends combinationally on an input
  assign avs_readdata     = rdata_q;
  assign avs_waitrequest  = wait_q;
  assign irq              = irq_q;
  assign int_pin_out      = pin_out_q;
  assign int_pin_oe       = pin_oe_q;
  assign below_limit_flag = below_q;
  assign above_limit_flag = above_q;
endmodule

// >>> rtl/ltirq_defs.vh
// shared constants of the light threshold interrupt logic
`ifndef LTIRQ_DEFS_VH
`define LTIRQ_DEFS_VH

// register byte addresses
`define LT_ADDR_CFG      4'h0
`define LT_ADDR_RES      4'h4
`define LT_ADDR_STS      4'h8
`define LT_ADDR_MSK      4'hc

// byte lane that carries every writable bit
`define LT_WR_LANE       0

// configuration bit positions
`define LT_CFG_ABOVE     6
`define LT_CFG_BELOW     5
`define LT_CFG_LATCH     4
`define LT_CFG_POL       3
`define LT_CFG_MASK      2
`define LT_CFG_FSEL_HI   1
`define LT_CFG_FSEL_LO   0

// configuration reset values
`define LT_LATCH_RST     1'b1
`define LT_POL_RST       1'b0
`define LT_MASK_RST      1'b0
`define LT_FSEL_RST      2'h0

// interrupt status bits
`define LT_STS_BELOW     0
`define LT_STS_ABOVE     1
`define LT_STS_RST       2'h0
`define LT_MSK_RST       2'h0

// result layout and range codes
`define LT_EXP_HI        15
`define LT_EXP_LO        12
`define LT_MANT_HI       11
`define LT_EXP_MAX       4'hb
`define LT_RN_AUTO       4'hc
`define LT_EXP_ZERO      4'h0

`endif

// >>> rtl/ltirq_lux_scale.v
// converts an exponent and mantissa word to a common lux scale
`timescale 1ns/10ps
`include "ltirq_defs.vh"

module ltirq_lux_scale (
  val,   // exponent and mantissa word
  lux    // mantissa shifted by exponent
);
  input  wire [15:0] val;  // word to scale
  output wire [22:0] lux;  // common scale value

  wire [3:0] exp_c;

  // codes above the top range are taken as the top range
  assign exp_c = (val[`LT_EXP_HI:`LT_EXP_LO] > `LT_EXP_MAX) ?
                 `LT_EXP_MAX : val[`LT_EXP_HI:`LT_EXP_LO];
  assign lux   = {11'h000, val[`LT_MANT_HI:0]} << exp_c;
endmodule

// >>> rtl/ltirq_fault_filter.v
// consecutive fault counter for one limit
`timescale 1ns/10ps
`include "ltirq_defs.vh"

module ltirq_fault_filter #(
  parameter CW = 4
) (
  ref_clk,    // clock
  rst_n,      // async reset, active low
  meas_valid, // one new measurement
  cond,       // this measurement is a fault
  fault_sel,  // consecutive count select
  hit,        // level: count reached
  hit_ev      // pulse: a measurement reached count
);
  input  wire       ref_clk;    // clock
  input  wire       rst_n;      // reset
  input  wire       meas_valid; // strobe
  input  wire       cond;       // fault
  input  wire [1:0] fault_sel;  // select
  output reg        hit;        // level
  output reg        hit_ev;     // pulse

  reg  [CW-1:0] cnt_q;
  reg  [CW-1:0] cnt_d;
  wire [CW-1:0] need;

  // 00 one, 01 two, 10 four, 11 eight faults
  function [CW-1:0] need_of;
    input [1:0] s;
    begin
      // the count doubles with each step of the select
      need_of = {{(CW-1){1'b0}}, 1'b1} << s;
    end
  endfunction

  assign need = need_of(fault_sel);

  // saturate at the need so the counter never wraps
  always @* begin
    if (!cond)
      cnt_d = {CW{1'b0}};
    else if (cnt_q >= need)
      cnt_d = cnt_q;
    else
      cnt_d = cnt_q + {{(CW-1){1'b0}}, 1'b1};
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= {CW{1'b0}};
      hit    <= 1'b0;
      hit_ev <= 1'b0;
    end else begin
      hit_ev <= 1'b0;
      if (meas_valid) begin
        cnt_q  <= cnt_d;
        hit    <= (cnt_d >= need);
        hit_ev <= cond && (cnt_d >= need);
      end
    end
  end
endmodule

// >>> sim/ltirq_chk_sva.sv
// bus, flag and pin timing checks for the threshold interrupt logic
`timescale 1ns/10ps
module ltirq_chk #(
  parameter CW = 4
) (
  input wire logic        ref_clk,          // clock
  input wire logic        rst_n,            // reset, active low
  input wire logic        avs_read,         // read request
  input wire logic        avs_write,        // write request
  input wire logic [31:0] avs_readdata,     // read data
  input wire logic        avs_waitrequest,  // stall
  input wire logic        irq,              // interrupt
  input wire logic        meas_valid,       // measurement strobe
  input wire logic        int_pin_out,      // pin value
  input wire logic        int_pin_oe,       // pin enable
  input wire logic        below_limit_flag, // below flag
  input wire logic        above_limit_flag  // above flag
);
  logic [2:0] mv_q;  // recent measurement strobes
  logic [2:0] acc_q; // recent completed accesses
  wire        done_w = (avs_read | avs_write) & ~avs_waitrequest;
  // cause history, so an output change can be traced back three cycles
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mv_q  <= 3'h0;
      acc_q <= 3'h0;
    end else begin
      mv_q  <= {mv_q[1:0], meas_valid};
      acc_q <= {acc_q[1:0], done_w};
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_wait_one: assert property ((avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest did not drop after one cycle");
  a_wait_back: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_cause: assert property ($fell(avs_waitrequest) |-> $past(avs_read | avs_write))
    else $error("waitrequest dropped without a request");
  a_rdata_hold: assert property ($changed(avs_readdata) |-> $past(avs_read | avs_write))
    else $error("read data changed outside a request");
  a_pin_open: assert property (int_pin_out == 1'b0)
    else $error("interrupt pin driven high");
  a_below_cause: assert property ($changed(below_limit_flag) |-> |mv_q || |acc_q)
    else $error("below flag changed without a cause");
  a_above_cause: assert property ($changed(above_limit_flag) |-> |mv_q || |acc_q)
    else $error("above flag changed without a cause");
  a_irq_cause: assert property ($changed(irq) |-> |mv_q || |acc_q)
    else $error("irq changed without a cause");
  a_pin_cause: assert property ($changed(int_pin_oe) |-> |mv_q || |acc_q)
    else $error("pin enable changed without a cause");
  c_below_hit: cover property (meas_valid ##2 below_limit_flag);
  c_irq_up: cover property ($rose(irq));
  c_read_done: cover property (avs_read && !avs_waitrequest);
endmodule

bind ltirq_top ltirq_chk #(.CW(CW)) i_chk (.ref_clk, .rst_n, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .irq, .meas_valid, .int_pin_out, .int_pin_oe,
  .below_limit_flag, .above_limit_flag);

// >>> sim/ltirq_pin_host.sv
// host side of the interrupt line: board pull-up and the level seen
`timescale 1ns/10ps
module ltirq_pin_host (
  input  wire logic pin_out, // value driven by the device
  input  wire logic pin_oe,  // device drives the line
  output wire logic pin_lvl  // resolved line level
);
  // a released line floats up through the board resistor
  assign pin_lvl = pin_oe ? pin_out : 1'b1;
endmodule

// >>> sim/tb.sv
// self-checking bench for the threshold interrupt logic
`timescale 1ns/10ps
module tb;
  logic        ref_clk = 1'b0; // 50 ns period
  logic        rst_n = 1'b0;   // reset, active low
  logic [3:0]  adr = 4'h0;     // bus address
  logic        rd = 1'b0;      // read request
  logic        wr = 1'b0;      // write request
  logic [31:0] wd = 32'h0;     // write data
  logic [3:0]  be = 4'hf;      // byte lanes
  logic        mv = 1'b0;      // measurement strobe
  logic [15:0] res = 16'h0;    // result word
  logic [15:0] lo = 16'h0;     // low limit
  logic [15:0] hi = 16'hffff;  // high limit
  logic [3:0]  rn = 4'hc;      // range number
  wire  [31:0] rdata;          // read data
  wire         wreq, irq, pin_out, pin_oe, pin_lvl, bflag, aflag;
  int          num_errors = 0;
  int          total_checks = 0;

  always #25 ref_clk = ~ref_clk;

  ltirq_top i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata),
    .avs_waitrequest(wreq), .irq(irq), .meas_valid(mv), .meas_result(res), .low_limit(lo),
    .high_limit(hi), .range_number(rn), .int_pin_in(pin_lvl), .int_pin_out(pin_out),
    .int_pin_oe(pin_oe), .below_limit_flag(bflag), .above_limit_flag(aflag));
  ltirq_pin_host i_host (.pin_out(pin_out), .pin_oe(pin_oe), .pin_lvl(pin_lvl));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one bus access; the request stands until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (n >= 50) num_errors++;
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  // one measurement, returning once flags and pin have settled
  task automatic meas(input logic [15:0] r, input logic [3:0] n = 4'hc);
    @(posedge ref_clk);
    mv <= 1'b1;
    res <= r;
    rn <= n;
    @(posedge ref_clk);
    mv <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  // lux scale: exponents above eleven count as eleven
  function automatic logic [22:0] lux(input logic [15:0] w);
    return {11'h0, w[11:0]} << ((w[15:12] > 4'hb) ? 4'hb : w[15:12]);
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    #2000000;
    num_errors++;
    tally_and_finish();
  end

  initial begin
    logic [31:0] q;
    logic [15:0] r;
    q = $urandom(32'he6e3);
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    // reset values, unmapped read, read-only bits and lane gating
    bus(0, 4'h0, 0, q); chk("cfg_rst", q, 32'h10);
    bus(0, 4'h8, 0, q); chk("sts_rst", q, 32'h0);
    bus(0, 4'hc, 0, q); chk("msk_rst", q, 32'h0);
    bus(0, 4'h2, 0, q); chk("unmapped", q, 32'h0);
    bus(1, 4'h0, 32'h7f, q);
    bus(0, 4'h0, 0, q); chk("cfg_rw", q, 32'h1f);
    be <= 4'h0;
    bus(1, 4'h0, 32'h0, q);
    be <= 4'hf;
    bus(0, 4'h0, 0, q); chk("cfg_lane", q, 32'h1f);
    // every fault count, transparent, pin active low
    lo <= 16'h1100;
    hi <= 16'hb0ff;
    for (int f = 0; f < 4; f++) begin
      bus(1, 4'h0, f, q);
      repeat ((1 << f) - 1) meas(16'h0001);
      meas(16'h0300);
      chk("below_restart", bflag, 0);
      repeat ((1 << f) - 1) meas(16'h0001);
      chk("below_short", bflag, 0);
      meas(16'h0001);
      chk("below_hit", bflag, 1);
      chk("pin_low", {pin_oe, pin_lvl, irq}, 3'b100);
      meas(16'h0300);
      chk("below_follow", {bflag, pin_oe}, 2'b00);
    end
    // random results with exponent masking on, every range code
    bus(1, 4'h0, 32'h04, q);
    hi <= 16'h2400;
    for (int i = 0; i < 24; i++) begin
      r = (i == 0) ? 16'h0200 : (i == 1) ? 16'h3200 : 16'($urandom) & 16'h33ff;
      meas(r, i[3:0]);
      chk("below_rnd", bflag, lux(r) < lux(16'h1100));
      chk("above_rnd", aflag, lux(r) > lux(16'h2400));
      bus(0, 4'h4, 0, q);
      chk("result_view", q, {16'h0, (i[3:0] < 4'hc) ? {4'h0, r[11:0]} : r});
    end
    // latched, active high pin, above event unmasked
    meas(16'h0300);
    bus(0, 4'h8, 0, q);
    bus(1, 4'hc, 32'h2, q);
    bus(1, 4'h0, 32'h18, q);
    repeat (3) @(posedge ref_clk);
    #1 chk("pin_idle", {pin_oe, pin_lvl, irq}, 3'b100);
    meas(16'h3fff);
    chk("alert", {aflag, pin_oe, pin_lvl, irq}, 4'b1011);
    meas(16'h0300);
    chk("held", {aflag, pin_oe}, 2'b10);
    bus(0, 4'h8, 0, q); chk("sts_ev", q, 32'h2);
    bus(0, 4'h0, 0, q); chk("cfg_flag", q, 32'h58);
    repeat (3) @(posedge ref_clk);
    #1 chk("cleared", {aflag, pin_oe, irq}, 3'b010);
    meas(16'h0001);
    chk("masked", {bflag, irq}, 2'b10);
    // unmask the below event: the pending status bit raises irq
    bus(1, 4'hc, 32'h3, q);
    #1 chk("irq_below", irq, 1'b1);
    bus(0, 4'h8, 0, q);
    chk("sts_below", q, 32'h1);
    #1 chk("irq_clear", irq, 1'b0);
    tally_and_finish();
  end
endmodule
